// *** core/sfcl_consts.vh ***
`ifndef SFCL_CONSTS_VH
`define SFCL_CONSTS_VH

// fabric arrangement codes
`define SFCL_ARR_W 2
`define SFCL_ARR_1X8 2'h0
`define SFCL_ARR_2X8 2'h1
`define SFCL_ARR_4X4 2'h2
`define SFCL_ARR_NONE 2'h3

// selector positions
`define SFCL_SEL_DEFAULT 1'b0
`define SFCL_SEL_USER 1'b1

// stored word layout: bit 0 selector, bits 2:1 user arrangement, bit 3 valid
`define SFCL_NV_W 4
`define SFCL_NV_SEL_BIT 0
`define SFCL_NV_ARR_LO 1
`define SFCL_NV_VALID_BIT 3
`define SFCL_NV_RESET 4'h0

// load sequencing
`define SFCL_LOAD_CYCLES 8'h04
`define SFCL_LINK_W 4
`define SFCL_LINK1 4'h1

`endif

// *** core/sfcl_loader.v ***
// What this block does
// - factory default arrangement is a single x8 link.
// - three arrangements selectable: one x8, two x8, four x4.
// - choosing a non-default arrangement moves selector to user and records it.
// - a new choice leaves the loaded fabric alone until the next link reset.
// - reselecting the original before the reset loads the original at that reset.
// - the management endpoint sits on the first link once the first load finishes; before that it reads 0.
// - selector position is kept in nonvolatile storage.
// - fabric is undefined from power-on until the load started by the first link reset finishes.
`timescale 1ns/1ps
`default_nettype none
`include "sfcl_consts.vh"

module sfcl_loader #(
  parameter LOAD_CYCLES = `SFCL_LOAD_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire pcie_rst,
  input wire sel_wr,
  input wire [1:0] sel_arr,
  output reg [1:0] fabric_arr_ff,
  output reg fabric_valid_ff,
  output reg loading_ff,
  output reg pending_sel_ff,
  output reg [1:0] pending_arr_ff,
  output reg [3:0] mgmt_link_ff,
  output reg sel_err_ff
);
  // idle: nothing loaded since power-on; load: image going in; run: fabric up
  localparam ST_IDLE = 2'h0;
  localparam ST_LOAD = 2'h1;
  localparam ST_RUN = 2'h2;
  localparam [7:0] LOAD_LAST = LOAD_CYCLES[7:0] - 8'h01;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [7:0] cnt_ff;
  reg pcie_rst_d_ff;
  reg [1:0] load_arr_ff;
  wire [3:0] nv_word;
  wire nv_wr;
  wire [3:0] nv_wdata;
  wire arr_ok;
  wire rst_rise;
  wire [1:0] img_arr;
  wire load_done;

  function [1:0] image_of;
    input [3:0] word;
    begin
      if (word[`SFCL_NV_SEL_BIT] == `SFCL_SEL_USER && word[`SFCL_NV_VALID_BIT]) begin
        image_of = word[`SFCL_NV_ARR_LO+1:`SFCL_NV_ARR_LO];
      end else begin
        image_of = `SFCL_ARR_1X8;
      end
    end
  endfunction

  function legal_arr;
    input [1:0] arr;
    begin
      legal_arr = (arr != `SFCL_ARR_NONE);
    end
  endfunction

  function rose_of;
    input now_v;
    input was_v;
    begin
      rose_of = now_v && !was_v;
    end
  endfunction

  assign arr_ok = legal_arr(sel_arr);
  assign nv_wr = sel_wr && arr_ok;
  // picking 1x8 puts the selector back to default, so the old image returns
  assign nv_wdata = (sel_arr == `SFCL_ARR_1X8) ? {1'b1, `SFCL_ARR_1X8, `SFCL_SEL_DEFAULT}
                                               : {1'b1, sel_arr, `SFCL_SEL_USER};
  assign rst_rise = rose_of(pcie_rst, pcie_rst_d_ff);
  assign img_arr = image_of(nv_word);

  sfcl_nv_store #(
    .WIDTH(`SFCL_NV_W)
  ) u_nv (
    .clk(clk),
    .rst(rst),
    .wr_en(nv_wr),
    .wr_data(nv_wdata),
    .rd_data_ff(nv_word)
  );

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (rst_rise) begin
          nxt_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        // a reset on the last load cycle beats finishing, else the restart would be lost
        if (rst_rise) begin
          nxt_state = ST_LOAD;
        end else if (cnt_ff == 8'h00) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (rst_rise) begin
          nxt_state = ST_LOAD;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  assign load_done = (state_ff == ST_LOAD) && (cnt_ff == 8'h00) && !rst_rise;

  always @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // detector idles low like the host's reset line, so no false load follows rst
  always @(posedge clk) begin
    if (rst) begin
      pcie_rst_d_ff <= 1'b0;
    end else begin
      pcie_rst_d_ff <= pcie_rst;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 8'h00;
    end else if (rst_rise) begin
      cnt_ff <= LOAD_LAST;
    end else if ((state_ff == ST_LOAD) && (cnt_ff != 8'h00)) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end

  // image latched at the reset edge; later selections wait for the next reset
  always @(posedge clk) begin
    if (rst) begin
      load_arr_ff <= `SFCL_ARR_NONE;
    end else if (rst_rise) begin
      load_arr_ff <= img_arr;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      fabric_arr_ff <= `SFCL_ARR_NONE;
    end else if (rst_rise) begin
      fabric_arr_ff <= `SFCL_ARR_NONE;
    end else if (load_done) begin
      // a new link reset restarts the load; the image goes in only once the count runs out
      fabric_arr_ff <= load_arr_ff;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      fabric_valid_ff <= 1'b0;
    end else if (rst_rise) begin
      fabric_valid_ff <= 1'b0;
    end else if (load_done) begin
      fabric_valid_ff <= 1'b1;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      loading_ff <= 1'b0;
    end else if (rst_rise) begin
      loading_ff <= 1'b1;
    end else if (load_done) begin
      loading_ff <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      mgmt_link_ff <= 4'h0;
    end else if (load_done) begin
      mgmt_link_ff <= `SFCL_LINK1;
    end
  end

  // pending view trails the store by one cycle; it reports only, it never loads
  always @(posedge clk) begin
    if (rst) begin
      pending_sel_ff <= `SFCL_SEL_DEFAULT;
    end else begin
      pending_sel_ff <= nv_word[`SFCL_NV_SEL_BIT];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      pending_arr_ff <= `SFCL_ARR_1X8;
    end else begin
      pending_arr_ff <= img_arr;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      sel_err_ff <= 1'b0;
    end else begin
      sel_err_ff <= sel_wr && !arr_ok;
    end
  end
endmodule // sfcl_loader

`default_nettype wire

// *** core/sfcl_nv_store.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sfcl_consts.vh"

// nonvolatile selector cell; the rst port only restarts the read register,
// the stored word itself is never cleared so it outlives power cycles
module sfcl_nv_store #(
  parameter WIDTH = `SFCL_NV_W
) (
  input wire clk,
  input wire rst,
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  output reg [WIDTH-1:0] rd_data_ff
);
  reg [WIDTH-1:0] cell_ff;
  reg init_ff;

  // an unwritten cell reads as the factory word
  initial cell_ff = `SFCL_NV_RESET;
  initial init_ff = 1'b0;

  always @(posedge clk) begin
    if (wr_en) begin
      cell_ff <= wr_data;
    end
    init_ff <= 1'b1;
  end

  always @(posedge clk) begin
    if (rst) begin
      // the stored word must stand at release, or a link reset on the first edge loads the factory image
      rd_data_ff <= init_ff ? cell_ff : `SFCL_NV_RESET;
    end else if (wr_en) begin
      rd_data_ff <= wr_data;
    end else begin
      rd_data_ff <= init_ff ? cell_ff : `SFCL_NV_RESET;
    end
  end
endmodule // sfcl_nv_store

`default_nettype wire

// *** testbench/sfcl_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfcl_host_model (
  input wire logic clk,
  input wire logic reboot,
  output logic pcie_rst
);
  initial pcie_rst = 1'b0;
  // link reset follows the reboot request one cycle later
  always @(posedge clk) pcie_rst <= reboot;
endmodule // sfcl_host_model
`default_nettype wire

// *** testbench/sfcl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfcl_props #(parameter int LOAD_CYCLES = 4) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pcie_rst,
  input wire logic sel_wr,
  input wire logic [1:0] sel_arr,
  input wire logic [1:0] fabric_arr_ff,
  input wire logic fabric_valid_ff,
  input wire logic loading_ff,
  input wire logic pending_sel_ff,
  input wire logic [1:0] pending_arr_ff,
  input wire logic [3:0] mgmt_link_ff,
  input wire logic sel_err_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence rise_s; $rose(pcie_rst); endsequence
  sequence quiet_s; (!$rose(pcie_rst)) [*4]; endsequence
  load_start_a: assert property (rise_s |=> loading_ff && !fabric_valid_ff && fabric_arr_ff == 2'h3)
    else $error("load start");
  load_done_a: assert property (rise_s ##1 quiet_s |=> fabric_valid_ff && !loading_ff && mgmt_link_ff == 4'h1)
    else $error("load end");
  image_a: assert property (((!sel_wr) [*3] ##0 rise_s) ##1 quiet_s |=> fabric_arr_ff == $past(pending_arr_ff, 5))
    else $error("image");
  undef_a: assert property (!fabric_valid_ff |-> fabric_arr_ff == 2'h3)
    else $error("undefined");
  hold_a: assert property (fabric_valid_ff && !$rose(pcie_rst) |=> fabric_valid_ff && $stable(fabric_arr_ff))
    else $error("hold");
  sel_user_a: assert property (sel_wr && sel_arr inside {2'h1, 2'h2} ##1 !sel_wr |=> pending_sel_ff)
    else $error("user sel");
  sel_dflt_a: assert property (sel_wr && sel_arr == 2'h0 ##1 !sel_wr |=> !pending_sel_ff && pending_arr_ff == 2'h0)
    else $error("default sel");
  sel_bad_a: assert property (sel_wr && sel_arr == 2'h3 |=> sel_err_ff)
    else $error("bad sel");
  // helper: cycles that the current load has been running
  int load_cnt = 0;
  always @(posedge clk) load_cnt <= (rst || !loading_ff || $rose(pcie_rst)) ? 0 : load_cnt + 1;
  load_len_a: assert property (loading_ff |-> load_cnt < LOAD_CYCLES)
    else $error("load too long");
  err_quiet_a: assert property (!(sel_wr && sel_arr == 2'h3) |=> !sel_err_ff)
    else $error("stray error");
endmodule // sfcl_props
bind sfcl_loader sfcl_props #(.LOAD_CYCLES(LOAD_CYCLES)) sfcl_props_inst (.clk(clk), .rst(rst), .pcie_rst(pcie_rst),
  .sel_wr(sel_wr), .sel_arr(sel_arr), .fabric_arr_ff(fabric_arr_ff), .fabric_valid_ff(fabric_valid_ff),
  .loading_ff(loading_ff), .pending_sel_ff(pending_sel_ff), .pending_arr_ff(pending_arr_ff),
  .mgmt_link_ff(mgmt_link_ff), .sel_err_ff(sel_err_ff));
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, rst = 1, reboot = 0, sel_wr = 0, valid, busy, psel, err;
  logic [1:0] sel_arr = 0, fab, parr;
  logic [3:0] mgmt;
  wire logic pcie_rst;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  sfcl_host_model sfcl_host_model_inst (.clk(clk), .reboot(reboot), .pcie_rst(pcie_rst));
  sfcl_loader #(.LOAD_CYCLES(4)) sfcl_loader_inst (.clk(clk), .rst(rst), .pcie_rst(pcie_rst), .sel_wr(sel_wr),
    .sel_arr(sel_arr), .fabric_arr_ff(fab), .fabric_valid_ff(valid), .loading_ff(busy), .pending_sel_ff(psel),
    .pending_arr_ff(parr), .mgmt_link_ff(mgmt), .sel_err_ff(err));
  task automatic go(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic pick(input logic [1:0] a);
    sel_wr = 1;
    sel_arr = a;
    go(1);
    sel_wr = 0;
    chk(err, a == 2'h3);
    go(2);
  endtask
  // reboot long enough for one clean rise, then wait out the load
  task automatic boot;
    reboot = 1;
    go(2);
    reboot = 0;
    chk(busy, 1);
    chk(valid, 0);
    go(6);
    chk(busy, 0);
    chk(valid, 1);
  endtask
  // a second link reset lands on the last load cycle; the load must start over
  task automatic t_restart;
    reboot = 1;
    go(1);
    reboot = 0;
    go(3);
    reboot = 1;
    go(1);
    reboot = 0;
    go(1);
    chk(busy, 1);
    chk(valid, 0);
    go(5);
    chk(valid, 1);
    chk(busy, 0);
    chk(fab, 2'h0);
    $display("test restart done");
  endtask
  task automatic t_user;
    for (int a = 1; a < 4; a++) begin
      pick(a[1:0]);
      chk(psel, 1);
      chk(parr, a == 3 ? 2 : a);
      chk(fab, a - 1);
      boot();
      chk(fab, a == 3 ? 2 : a);
    end
    rst = 1;
    go(1);
    rst = 0;
    go(2);
    chk(psel, 1);
    chk(fab, 2'h3);
    boot();
    chk(fab, 2'h2);
    $display("test user done");
  endtask
  task automatic t_revert;
    pick(2'h1);
    pick(2'h0);
    chk(psel, 0);
    boot();
    chk(fab, 2'h0);
    $display("test revert done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 600) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    go(6);
    rst = 0;
    chk(fab, 2'h3);
    boot();
    chk(fab, 2'h0);
    chk(mgmt, 4'h1);
    $display("test default done");
    t_user();
    t_revert();
    t_restart();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
